// file: bench/flash_bridge_properties.sv
`timescale 1ns/10ps
// watches host answers and flash strobes at the bridge's own ports
module flash_bridge_chk (
    input wire logic        clk,                      // clock
    input wire logic        rst,                      // sync reset, high
    input wire logic        req,                      // host data phase pending
    input wire logic        hit,                      // request decodes to flash
    input wire logic        trdy,                     // data phase done
    input wire logic        stop,                     // disconnect or retry
    input wire logic        retry,                    // stop is a retry
    input wire logic        boot_phase,               // rom shadowing
    input wire logic [1:0]  flash_write_permit_field, // write permit
    input wire logic [18:0] flash_addr,               // flash address
    input wire logic        flash_dq_oe,              // data out enable
    input wire logic        flash_sel_n,              // chip select
    input wire logic        flash_rd_n,               // read strobe
    input wire logic        flash_wr_n                // write strobe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // a byte cycle keeps select low for roughly a quarter microsecond
    AST_BYTE_LEN: assert property (
        $fell(flash_sel_n) |-> (!flash_sel_n)[*8] ##[14:22] flash_sel_n)
        else $error("flash byte cycle length out of range");
    // idle gap after every byte cycle
    AST_GAP: assert property ($rose(flash_sel_n) |-> flash_sel_n[*2])
        else $error("flash select back low without gap");
    AST_IDLE: assert property (flash_sel_n |-> flash_rd_n && flash_wr_n)
        else $error("strobe active while flash deselected");
    AST_TRDY_STOP: assert property (trdy |-> stop)
        else $error("data phase done without disconnect");
    AST_RETRY_STOP: assert property (retry |-> stop && !trdy)
        else $error("retry not a plain stop");
    AST_TAKEN: assert property (trdy |-> $past(req && hit))
        else $error("data phase done with no decoded request");
    AST_WR_PERMIT: assert property (
        !flash_wr_n |-> flash_write_permit_field == flash_bridge_pkg::WPERMIT_ALLOW)
        else $error("flash write while writes blocked");
    AST_ADDR_HOLD: assert property (
        !flash_sel_n && !$past(flash_sel_n) |-> $stable(flash_addr))
        else $error("flash address moved inside a byte cycle");
    AST_OE: assert property (flash_dq_oe |-> flash_rd_n)
        else $error("data driven during flash read");
    AST_BOOT: assert property (boot_phase && $past(boot_phase) |-> !retry)
        else $error("retry during rom shadowing");
endmodule

// file: bench/flash_model.sv
`timescale 1ns/10ps
// byte-wide flash stand-in, smaller than the bridge's reach
module flash_model #(
    parameter int AW = 17                  // 128 KB part
) (
    input  wire logic        clk,          // clock
    input  wire logic [18:0] addr,         // address pins
    input  wire logic [7:0]  dq_out,       // data from bridge
    input  wire logic        dq_oe,        // bridge drives data
    input  wire logic        sel_n,        // chip select
    input  wire logic        rd_n,         // read strobe
    input  wire logic        wr_n,         // write strobe
    output logic      [7:0]  dq_in         // data to bridge
);
    logic [7:0] mem [2**AW];               // cell array
    logic [7:0] last = 8'h5A;              // last byte put out
    wire        drv = !sel_n && !rd_n;     // part drives the bus
    // only low bits decode, so upper addresses alias; released bus shows junk
    assign dq_in = drv ? mem[addr[AW-1:0]] : ~last;
    // remember last output so a stale byte never looks valid
    always @(posedge clk) begin
        if (drv) last <= dq_in;
    end
    // plain byte write, no command decode
    always @(posedge clk) begin
        if (!sel_n && !wr_n && dq_oe) begin
            mem[addr[AW-1:0]] <= dq_out;
        end
    end
endmodule

// file: bench/tb_top.sv
`timescale 1ns/10ps
// drives config, eeprom words and host accesses against a model flash
module tb_top;
    logic        clk, rst, cfg_wr, ee_load, boot_phase, mem_space_en; // control
    logic        io_space_en, req, req_io, req_wr, hit, trdy, stop, retry; // host
    logic        flash_dq_oe, flash_sel_n, flash_rd_n, flash_wr_n, sel_q; // flash
    logic [7:0]  cfg_ofs, ee_word_adr, flash_dq_in, flash_dq_out; // bytes
    logic [31:0] cfg_wdata, cfg_rdata, req_addr, req_wdata, rdata, a, d, got; // words
    logic [15:0] ee_word;                                       // eeprom word
    logic [1:0]  ee_size_code, flash_write_permit_field;        // eeprom fields
    logic [3:0]  req_be;                                        // byte lanes
    logic [18:0] flash_addr;                                    // flash address
    int          n_fail, num_checks, n_retry, n_wait, n_byte, b; // tallies
    int          seed = 32'hd95b;                               // fixed seed
    localparam logic [31:0] BASE = 32'h4000_0000;               // flash window
    localparam logic [31:0] ROM  = 32'h5000_0000;               // rom window
    flash_access_bridge uut (
        .clk, .rst, .cfg_wr, .cfg_ofs, .cfg_wdata, .cfg_rdata, .ee_load, .ee_word_adr,
        .ee_word, .ee_size_code, .flash_write_permit_field, .boot_phase, .mem_space_en,
        .io_space_en, .req, .req_io, .req_wr, .req_addr, .req_be, .req_wdata, .hit,
        .trdy, .stop, .retry, .rdata, .flash_addr, .flash_dq_in, .flash_dq_out,
        .flash_dq_oe, .flash_sel_n, .flash_rd_n, .flash_wr_n
    );
    flash_model fl (
        .clk, .addr(flash_addr), .dq_out(flash_dq_out), .dq_oe(flash_dq_oe),
        .sel_n(flash_sel_n), .rd_n(flash_rd_n), .wr_n(flash_wr_n), .dq_in(flash_dq_in)
    );
    // free-running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // count byte cycles by select falls
    always @(posedge clk) begin
        if (sel_q === 1'b1 && flash_sel_n === 1'b0) n_byte++;
        sel_q <= flash_sel_n;
    end
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("BAD at %0t got %h exp %h", $time, g, e);
        end
    endtask
    // expected merge of a masked write into an old word
    function automatic logic [31:0] merge(input logic [31:0] o, n, input logic [3:0] be);
        for (int i = 0; i < 4; i++) merge[8*i +: 8] = be[i] ? n[8*i +: 8] : o[8*i +: 8];
    endfunction
    task automatic cfg(input logic [7:0] o, input logic [31:0] v);
        {cfg_ofs, cfg_wdata, cfg_wr} = {o, v, 1'b1};
        tick();
        cfg_wr = 1'b0;
        tick();
    endtask
    task automatic ee(input logic [7:0] w, input logic [15:0] v, input logic [1:0] s);
        {ee_word_adr, ee_word, ee_size_code, ee_load} = {w, v, s, 1'b1};
        tick();
        ee_load = 1'b0;
        tick();
    endtask
    // one host access; after a stop without data the host backs off a cycle
    task automatic host(input logic w, input logic [31:0] ad, input logic [3:0] be,
                        input logic [31:0] wd, output logic [31:0] rd);
        n_retry = 0;
        n_wait = 0;
        {req_wr, req_addr, req_be, req_wdata, req} = {w, ad, be, wd, 1'b1};
        while (trdy !== 1'b1 && n_wait < 3000) begin
            tick();
            n_wait++;
            if (stop === 1'b1 && trdy !== 1'b1) begin
                n_retry++;
                req = 1'b0;
                tick();
                req = 1'b1;
            end
        end
        rd = rdata;
        if (n_wait >= 3000) n_fail++;
        req = 1'b0;
        tick();
    endtask
    task automatic test_done();
        if (n_fail == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // the run needs a few thousand cycles; far beyond that is a hang
    initial begin
        repeat (50000) @(posedge clk);
        n_fail++;
        test_done();
    end
    // main sequence
    initial begin
        {cfg_wr, ee_load, boot_phase, req, req_io, req_wr, req_be, ee_size_code} = '0;
        {cfg_ofs, ee_word_adr, cfg_wdata, req_addr, req_wdata, ee_word} = '0;
        {mem_space_en, io_space_en, rst} = 3'h7;
        flash_write_permit_field = flash_bridge_pkg::WPERMIT_ALLOW;
        {n_fail, num_checks, n_byte} = '0;
        repeat (16) @(posedge clk);
        #1 rst = 1'b0;
        // bad marker keeps 512 KB; good marker lets size code shrink both windows
        ee(8'h00, 16'h8000, 2'h3);
        ee(8'h01, 16'h0000, 2'h1);
        cfg(8'h14, 32'hFFFF_FFFF);
        chk(cfg_rdata, 32'hFFF8_0000);
        ee(8'h00, 16'h4000, 2'h3);
        ee(8'h01, 16'h0000, 2'h1);
        cfg(8'h14, 32'hFFFF_FFFF);
        chk(cfg_rdata, 32'hFFFE_0000);
        cfg(8'h30, 32'hFFFF_FFFF);
        chk(cfg_rdata, 32'hFFFE_0001);
        ee(8'h01, 16'h0000, 2'h3);
        cfg(8'h30, ROM | 32'h1);
        cfg(8'h18, BASE);
        chk(cfg_rdata, BASE);
        // memory space off, then an address outside the window: no decode
        for (int i = 0; i < 2; i++) begin
            {mem_space_en, req_addr, req} = {i[0], i[0] ? 32'h6000_0000 : BASE, 1'b1};
            #1 chk({31'h0, hit}, 32'h0);
            req = 1'b0;
            tick();
        end
        // random dwords: four byte cycles each, reads retried until data is in
        repeat (6) begin
            a = BASE | (32'($random(seed)) & 32'h7_FFFC);
            d = $random(seed);
            host(1'b1, a, 4'hF, d, got);
            host(1'b0, a, 4'hF, 32'h0, got);
            chk(got, d);
            chk(32'(n_retry > 0), 32'h1);
        end
        // 128 KB part: 128 KB higher lands on the same bytes
        a = BASE | 32'h100;
        host(1'b1, a, 4'hF, 32'hA55A_3CC3, got);
        host(1'b0, a + 32'h2_0000, 4'hF, 32'h0, got);
        chk(got, 32'hA55A_3CC3);
        // two lanes enabled: two byte cycles, other bytes untouched
        b = n_byte;
        host(1'b1, a, 4'h5, 32'h1122_3344, got);
        repeat (80) tick();
        chk(32'(n_byte - b), 32'h2);
        d = merge(32'hA55A_3CC3, 32'h1122_3344, 4'h5);
        b = n_byte;
        host(1'b0, a, 4'hA, 32'h0, got);
        chk(32'(n_byte - b), 32'h2);
        chk(merge(32'h0, got, 4'hA), merge(32'h0, d, 4'hA));
        // writes blocked: answered but the flash keeps its data
        flash_write_permit_field = flash_bridge_pkg::WPERMIT_RESET;
        host(1'b1, a, 4'hF, 32'hDEAD_BEEF, got);
        {flash_write_permit_field, req_io} = {flash_bridge_pkg::WPERMIT_ALLOW, 1'b1};
        host(1'b0, a, 4'hF, 32'h0, got);
        chk(got, d);
        // rom shadowing: held with wait states, never retried
        {boot_phase, req_io} = 2'h2;
        host(1'b0, ROM | 32'h100, 4'hF, 32'h0, got);
        boot_phase = 1'b0;
        chk(got, d);
        chk(32'(n_retry), 32'h0);
        chk(32'(n_wait > 25), 32'h1);
        test_done();
    end
endmodule
bind flash_access_bridge flash_bridge_chk chk (
    .clk, .rst, .req, .hit, .trdy, .stop, .retry, .boot_phase, .flash_write_permit_field,
    .flash_addr, .flash_dq_oe, .flash_sel_n, .flash_rd_n, .flash_wr_n
);

// file: rtl/flash_access_bridge.sv
`timescale 1ns/10ps
// Operation
// - flash cycle on window hits, rom at boot
// - decode against flash or rom base
// - byte-wide flash, 512 KB address
// - small flash wraps via low address bits
// - eeprom size bits size both windows
// - split writes, assemble reads, bytewise
// - byte read takes about 256 ns
// - retry host while byte read runs
// - boot shadowing may hold long waits
// - flash also reachable through i/o mapping
// - accept config only with marker 01b
// - never compute or insert checksum
// - disconnect on first data phase always
// - withhold trdy until read data valid
// - writes gated by write permit field
module flash_access_bridge (
    input  wire logic        clk,           // bus clock, 100 MHz
    input  wire logic        rst,           // synchronous reset, high
    // configuration writes to window bases
    input  wire logic        cfg_wr,        // config write strobe, pulse
    input  wire logic [7:0]  cfg_ofs,       // config offset
    input  wire logic [31:0] cfg_wdata,     // config write data
    output logic [31:0]      cfg_rdata,     // config read data for cfg_ofs
    // eeprom load results
    input  wire logic        ee_load,       // eeprom word valid, pulse
    input  wire logic [7:0]  ee_word_adr,   // eeprom word index
    input  wire logic [15:0] ee_word,       // eeprom word content
    input  wire logic [1:0]  ee_size_code,  // flash size bits from eeprom
    input  wire logic [1:0]  flash_write_permit_field, // write permit from control reg
    input  wire logic        boot_phase,    // system still shadowing rom
    input  wire logic        mem_space_en,  // memory access enabled
    input  wire logic        io_space_en,   // i/o access enabled
    // decoded host target request
    input  wire logic        req,           // host data phase pending, level
    input  wire logic        req_io,        // request is an i/o space access
    input  wire logic        req_wr,        // 1 write, 0 read
    input  wire logic [31:0] req_addr,      // host byte address, dword aligned
    input  wire logic [3:0]  req_be,        // byte enables, high active
    input  wire logic [31:0] req_wdata,     // host write data
    output logic             hit,           // request decodes to flash
    output logic             trdy,          // data phase done, pulse
    output logic             stop,          // disconnect or retry, pulse
    output logic             retry,         // stop is a retry, pulse
    output logic [31:0]      rdata,         // assembled read data
    // flash pins
    output logic [18:0]      flash_addr,    // flash address
    input  wire logic [7:0]  flash_dq_in,   // flash data in
    output logic [7:0]       flash_dq_out,  // flash data out
    output logic             flash_dq_oe,   // flash data output enable
    output logic             flash_sel_n,   // chip select, low active
    output logic             flash_rd_n,    // output enable, low active
    output logic             flash_wr_n     // write strobe, low active
);
    typedef enum {IDLE, PICK, RUN, WAIT_GAP, DONE} state_t;

    state_t      state_reg;                 // byte sequencer state
    logic [31:0] flash_base_reg;            // flash window base
    logic [31:0] rom_base_reg;              // rom window base
    logic [1:0]  size_reg;                  // accepted size code
    logic        cfg_ok_reg;                // eeprom marker accepted
    logic [3:0]  be_left_reg;               // bytes still to move
    logic [1:0]  lane_reg;                  // lane now in flight
    logic [31:0] data_reg;                  // read assembly register
    logic [31:0] tag_reg;                   // address of the read being fetched
    logic        ready_reg;                 // fetched read waits for host
    logic        wr_run_reg;                // current access is a write
    logic [18:0] acc_addr_reg;              // flash address of the access
    logic [31:0] wdata_reg;                 // captured write data
    logic [5:0]  gap_reg;                   // idle gap timer
    logic [7:0]  dq_s1_reg;                 // data pin sync stage 1
    logic [7:0]  dq_s2_reg;                 // data pin sync stage 2
    logic        cyc_start;                 // launch one byte cycle
    logic        cyc_done;                  // byte cycle ended
    logic [7:0]  cyc_rdata;                 // byte read back
    logic        flash_hit;                 // address in flash window
    logic        rom_hit;                   // address in rom window
    logic [31:0] win_mask;                  // window address mask
    logic        wr_allowed;                // permit field lets writes through

    // mask of bits inside a window of the given size code
    function automatic logic [31:0] size_mask(input logic [1:0] code);
        size_mask = (32'h1 << (flash_bridge_pkg::SIZE_MIN_SHIFT + int'(code))) - 32'h1;
    endfunction

    // lowest enabled lane still to move
    function automatic logic [1:0] first_lane(input logic [3:0] be);
        if (be[0]) begin
            first_lane = 2'h0;
        end else if (be[1]) begin
            first_lane = 2'h1;
        end else if (be[2]) begin
            first_lane = 2'h2;
        end else begin
            first_lane = 2'h3;
        end
    endfunction

    // data pins leave the flash domain, two flops before use
    always_ff @(posedge clk) begin
        if (rst) begin
            dq_s1_reg <= 8'h00;
            dq_s2_reg <= 8'h00;
        end else begin
            dq_s1_reg <= flash_dq_in;
            dq_s2_reg <= dq_s1_reg;
        end
    end

    // eeprom config taken only under a valid marker, checksum never looked at
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_ok_reg <= 1'b0;
            size_reg   <= flash_bridge_pkg::SIZE_RESET;
        end else if (ee_load && ee_word_adr == 8'h00) begin
            cfg_ok_reg <= (ee_word[flash_bridge_pkg::MARKER_HI:flash_bridge_pkg::MARKER_LO]
                           == flash_bridge_pkg::MARKER_VALID);
        end else if (ee_load && cfg_ok_reg && ee_word_adr <= flash_bridge_pkg::CFG_LAST_WORD) begin
            size_reg <= ee_size_code;
        end
    end

    // base registers: address bits inside the window are read-only zero
    always_ff @(posedge clk) begin
        if (rst) begin
            flash_base_reg <= flash_bridge_pkg::WORD_RESET;
            rom_base_reg   <= flash_bridge_pkg::WORD_RESET;
        end else if (cfg_wr) begin
            if (cfg_ofs == flash_bridge_pkg::FLASH_BASE_OFS ||
                cfg_ofs == flash_bridge_pkg::FLASH_BASE_OFS_HI) begin
                flash_base_reg <= cfg_wdata & ~size_mask(size_reg);
            end else if (cfg_ofs == flash_bridge_pkg::ROM_BASE_OFS) begin
                rom_base_reg <= (cfg_wdata & ~size_mask(size_reg)) | {31'h0, cfg_wdata[0]};
            end
        end
    end

    // config read back shows the sized bases
    always_comb begin
        if (cfg_ofs == flash_bridge_pkg::FLASH_BASE_OFS ||
            cfg_ofs == flash_bridge_pkg::FLASH_BASE_OFS_HI) begin
            cfg_rdata = flash_base_reg & ~size_mask(size_reg);
        end else if (cfg_ofs == flash_bridge_pkg::ROM_BASE_OFS) begin
            cfg_rdata = (rom_base_reg & ~size_mask(size_reg)) | {31'h0, rom_base_reg[0]};
        end else begin
            cfg_rdata = 32'h0;
        end
    end

    // window decode; rom window only counts while booting and enabled
    always_comb begin
        win_mask   = size_mask(size_reg);
        flash_hit  = (req_io ? io_space_en : mem_space_en) &&
                     ((req_addr & ~win_mask) == (flash_base_reg & ~win_mask));
        rom_hit    = !req_io && mem_space_en && boot_phase && rom_base_reg[0] &&
                     ((req_addr & ~win_mask) == (rom_base_reg & ~win_mask));
        hit        = req && (flash_hit || rom_hit);
        wr_allowed = (flash_write_permit_field == flash_bridge_pkg::WPERMIT_ALLOW);
    end

    // byte sequencer: lowest lane first, each lane its own flash cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg    <= IDLE;
            be_left_reg  <= 4'h0;
            lane_reg     <= 2'h0;
            data_reg     <= flash_bridge_pkg::WORD_RESET;
            tag_reg      <= flash_bridge_pkg::WORD_RESET;
            ready_reg    <= 1'b0;
            wr_run_reg   <= 1'b0;
            acc_addr_reg <= 19'h0;
            wdata_reg    <= flash_bridge_pkg::WORD_RESET;
            gap_reg      <= 6'h00;
        end else begin
            case (state_reg)
            IDLE: begin
                // a finished read is handed over once the host comes back for it
                if (ready_reg && hit && !req_wr && req_addr == tag_reg) begin
                    ready_reg <= 1'b0;
                end else if (hit && !ready_reg && (!req_wr || wr_allowed)) begin
                    be_left_reg  <= req_be;
                    wr_run_reg   <= req_wr;
                    acc_addr_reg <= req_addr[flash_bridge_pkg::FLASH_AW-1:0] &
                                    win_mask[flash_bridge_pkg::FLASH_AW-1:0];
                    wdata_reg    <= req_wdata;
                    tag_reg      <= req_addr;
                    data_reg     <= flash_bridge_pkg::WORD_RESET;
                    state_reg    <= PICK;
                end
            end
            PICK: begin
                if (be_left_reg == 4'h0) begin
                    state_reg <= DONE;
                end else begin
                    lane_reg  <= first_lane(be_left_reg);
                    state_reg <= RUN;
                end
            end
            RUN: begin
                if (cyc_done) begin
                    be_left_reg[lane_reg] <= 1'b0;
                    if (!wr_run_reg) begin
                        data_reg[8*lane_reg +: 8] <= cyc_rdata;
                    end
                    gap_reg   <= 6'h00;
                    state_reg <= WAIT_GAP;
                end
            end
            WAIT_GAP: begin
                // keeps select high between bytes of one access
                gap_reg <= gap_reg + 6'h01;
                if (gap_reg == flash_bridge_pkg::GAP_CYCLES) begin
                    state_reg <= PICK;
                end
            end
            default: begin
                // writes were answered at capture and just go idle; reads wait for the host
                ready_reg <= !wr_run_reg;
                state_reg <= IDLE;
            end
            endcase
        end
    end

    // launch in RUN; done masks the closing edge so no second cycle slips out
    assign cyc_start = (state_reg == RUN) && !cyc_done;

    flash_byte_cycle u_cycle (
        .clk       (clk),
        .rst       (rst),
        .start     (cyc_start),
        .wr        (wr_run_reg),
        .addr      (acc_addr_reg + {17'h0, lane_reg}),
        .wdata     (wdata_reg[8*lane_reg +: 8]),
        .pin_rdata (dq_s2_reg),
        .done      (cyc_done),
        .rdata     (cyc_rdata),
        .pin_addr  (flash_addr),
        .pin_wdata (flash_dq_out),
        .pin_oe    (flash_dq_oe),
        .sel_n     (flash_sel_n),
        .rd_n      (flash_rd_n),
        .wr_n      (flash_wr_n)
    );

    // host answer: reads retried while busy, every phase ends with stop
    always_ff @(posedge clk) begin
        if (rst) begin
            trdy  <= 1'b0;
            stop  <= 1'b0;
            retry <= 1'b0;
            rdata <= flash_bridge_pkg::WORD_RESET;
        end else begin
            trdy  <= 1'b0;
            stop  <= 1'b0;
            retry <= 1'b0;
            if (hit && !trdy && !stop) begin
                if (state_reg == IDLE && ready_reg && !req_wr && req_addr == tag_reg) begin
                    trdy  <= 1'b1;
                    stop  <= 1'b1;
                    rdata <= data_reg;
                end else if (req_wr && !wr_allowed && state_reg == IDLE) begin
                    trdy <= 1'b1;
                    stop <= 1'b1;
                end else if (req_wr && state_reg == IDLE && !ready_reg) begin
                    // write completes once captured; bytes then go out in order
                    trdy <= 1'b1;
                    stop <= 1'b1;
                end else if (!boot_phase) begin
                    stop  <= 1'b1;
                    retry <= 1'b1;
                end
                // in boot, the host is held in wait states until data is ready
            end
        end
    end
endmodule

// file: rtl/flash_bridge_pkg.sv
package flash_bridge_pkg;
    // configuration offsets of the two window base registers
    localparam logic [7:0]  FLASH_BASE_OFS    = 8'h14;      // flash window base, primary
    localparam logic [7:0]  FLASH_BASE_OFS_HI = 8'h18;      // flash window base, alternate
    localparam logic [7:0]  ROM_BASE_OFS      = 8'h30;      // boot rom window base
    // flash geometry
    localparam int          FLASH_AW          = 19;         // 512 KB byte address
    localparam int          FLASH_DW          = 8;          // byte-wide flash data
    // eeprom handling
    localparam logic [1:0]  MARKER_VALID      = 2'h1;       // programmed marker must read 01b
    localparam logic [7:0]  CFG_LAST_WORD     = 8'h0F;      // last hardware config word
    localparam int          MARKER_HI         = 15;         // marker field position
    localparam int          MARKER_LO         = 14;
    // size code: window = 64 KB << code, code 0..3 gives 64..512 KB
    localparam logic [1:0]  SIZE_RESET        = 2'h3;       // size code after reset
    localparam int          SIZE_MIN_SHIFT    = 16;         // log2 of smallest window
    // write permit field values
    localparam logic [1:0]  WPERMIT_RESET     = 2'h1;       // writes blocked after reset
    localparam logic [1:0]  WPERMIT_ALLOW     = 2'h2;       // writes allowed
    // timing
    localparam int          CLK_NS            = 10;         // clock period in ns
    localparam int          BYTE_CYCLE_NS     = 256;        // one flash byte cycle
    localparam int          BYTE_CYCLES       = (BYTE_CYCLE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [5:0]  BYTE_CYC_LAST     = 6'(BYTE_CYCLES - 1);
    localparam logic [5:0]  GAP_CYCLES        = 6'h01;      // idle gap between byte cycles
    localparam logic [31:0] WORD_RESET        = 32'h0;      // data/base value after reset
endpackage

// file: rtl/flash_byte_cycle.sv
`timescale 1ns/10ps
// one timed byte cycle on the flash pins; strobes idle between cycles
module flash_byte_cycle (
    input  wire logic        clk,         // clock
    input  wire logic        rst,         // synchronous reset, high
    input  wire logic        start,       // begin a byte cycle, level, taken while idle
    input  wire logic        wr,          // 1 write, 0 read
    input  wire logic [18:0] addr,        // byte address
    input  wire logic [7:0]  wdata,       // write byte
    input  wire logic [7:0]  pin_rdata,   // synchronised flash data pins
    output logic             done,        // cycle finished, pulse
    output logic [7:0]       rdata,       // captured read byte
    output logic [18:0]      pin_addr,    // flash address pins
    output logic [7:0]       pin_wdata,   // flash data out
    output logic             pin_oe,      // data pin output enable
    output logic             sel_n,       // chip select, low active
    output logic             rd_n,        // output enable strobe, low active
    output logic             wr_n         // write strobe, low active
);
    logic [5:0] cnt_reg;                  // cycle timer
    logic       busy_reg;                 // a cycle is in flight
    logic       wr_reg;                   // direction of the cycle

    // timer and direction; strobes only live while busy
    always_ff @(posedge clk) begin
        if (rst) begin
            busy_reg <= 1'b0;
            cnt_reg  <= 6'h00;
            wr_reg   <= 1'b0;
        end else if (start && !busy_reg) begin
            busy_reg <= 1'b1;
            cnt_reg  <= 6'h00;
            wr_reg   <= wr;
        end else if (busy_reg) begin
            if (cnt_reg == flash_bridge_pkg::BYTE_CYC_LAST) begin
                busy_reg <= 1'b0;
            end
            cnt_reg <= cnt_reg + 6'h01;
        end
    end

    // address and data are held steady through the whole cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_addr  <= 19'h0;
            pin_wdata <= 8'h00;
        end else if (start && !busy_reg) begin
            pin_addr  <= addr;
            pin_wdata <= wdata;
        end
    end

    // capture read data at the very end of the 26-clock, 260 ns cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= 8'h00;
            done  <= 1'b0;
        end else begin
            done <= busy_reg && (cnt_reg == flash_bridge_pkg::BYTE_CYC_LAST);
            if (busy_reg && !wr_reg && cnt_reg == flash_bridge_pkg::BYTE_CYC_LAST) begin
                rdata <= pin_rdata;
            end
        end
    end

    // strobes: write pulse released one cycle early so data holds past it
    always_comb begin
        sel_n  = !busy_reg;
        rd_n   = !(busy_reg && !wr_reg);
        wr_n   = !(busy_reg && wr_reg && cnt_reg != flash_bridge_pkg::BYTE_CYC_LAST);
        pin_oe = busy_reg && wr_reg;
    end
endmodule
